// *** ebms_pkg.sv ***
// shared constants, register map and carrier types of the backup mode supervisor
package ebms_pkg;

  // register byte offsets
  localparam logic [7:0] EBMS_OFS_CTRL   = 8'h00;
  localparam logic [7:0] EBMS_OFS_CAL    = 8'h04;
  localparam logic [7:0] EBMS_OFS_SPEED  = 8'h08;
  localparam logic [7:0] EBMS_OFS_IDLE   = 8'h0C;
  localparam logic [7:0] EBMS_OFS_PRESS  = 8'h10;
  localparam logic [7:0] EBMS_OFS_SENSV  = 8'h14;
  localparam logic [7:0] EBMS_OFS_STATUS = 8'h18;
  localparam logic [7:0] EBMS_OFS_GOV    = 8'h1C;
  localparam logic [7:0] EBMS_OFS_FAULT  = 8'h20;
  localparam logic [7:0] EBMS_OFS_AMB    = 8'h24;

  // CTRL bit positions
  localparam int EBMS_B_CAM_OK     = 0;
  localparam int EBMS_B_CRANK_OK   = 1;
  localparam int EBMS_B_SYNCED     = 2;
  localparam int EBMS_B_RUNNING    = 3;
  localparam int EBMS_B_NO_COMM    = 4;
  localparam int EBMS_B_BAD_TELEG  = 5;
  localparam int EBMS_B_CAN_DEFECT = 6;
  localparam int EBMS_B_FAULT_ACT  = 7;
  localparam int EBMS_B_MODE_VALID = 8;
  localparam int EBMS_B_MODE_LO    = 9;
  localparam int EBMS_B_AMB_FAULT  = 11;
  localparam int EBMS_B_BOOST_BAD  = 12;
  localparam int EBMS_B_BOOSTPATH  = 13;
  localparam int EBMS_B_BOOST_DEV  = 14;
  localparam int EBMS_B_STARTER_LO = 15;
  localparam int EBMS_B_BUF_FAIL   = 16;
  localparam int EBMS_B_MAIN_FAIL  = 17;
  localparam int EBMS_B_IGN_ON     = 18;
  localparam int EBMS_B_ABOVE_THR  = 19;

  // CAL fields: [15:0] manual, [31:16] automatic backup speed; SPEED: [15:0] actual, [31:16] limit
  localparam logic [31:0] EBMS_CAL_RESET  = 32'h0514_05DC;
  localparam logic [31:0] EBMS_IDLE_RESET = 32'h0000_0258;
  localparam logic [15:0] EBMS_MP2_MIN    = 16'h0320;  // 800 rpm
  localparam logic [15:0] EBMS_MP2_MAX    = 16'h0514;  // 1300 rpm
  localparam logic [15:0] EBMS_RAMP_STEP  = 16'h0001;
  localparam logic [15:0] EBMS_AMB_CONST  = 16'h03F2;
  localparam logic [15:0] EBMS_BOOST_CONST = 16'h0080;
  localparam logic [15:0] EBMS_SENS_MIN   = 16'h0020;
  localparam logic [15:0] EBMS_SENS_MAX   = 16'h0FC0;

  // control cycle: 1 ms at 50 MHz
  localparam int EBMS_CLK_HZ      = 50_000_000;
  localparam int EBMS_CYCLE_US    = 1000;
  localparam int EBMS_CYCLE_CLKS  = EBMS_CLK_HZ / 1_000_000 * EBMS_CYCLE_US;

  localparam logic [1:0] EBMS_RESP_OKAY   = 2'b00;
  localparam logic [1:0] EBMS_RESP_SLVERR = 2'b10;

  typedef enum logic [2:0]
  {
    EBMS_ST_NORMAL = 3'b000,
    EBMS_ST_CRANK  = 3'b001,
    EBMS_ST_CAM    = 3'b010,
    EBMS_ST_CAN0   = 3'b011,
    EBMS_ST_CAN1   = 3'b100,
    EBMS_ST_CAN2   = 3'b101,
    EBMS_ST_MP2    = 3'b110,
    EBMS_ST_RECOV  = 3'b111
  } ebms_state_t;

  typedef struct packed
  {
    logic        double_inject;
    logic        engine_protect;
    logic        cam_timing;
    logic        inject_lock;
    logic        starter_lock;
    logic        boost_ctrl_off;
    logic        brake_unavail;
    logic        amb_unavail;
    logic        can_silent;
  } ebms_act_t;

endpackage

// *** ebms_ramp.sv ***
// single ramp unit that climbs a value toward a target by a fixed step per enable and drops straight to a lower target
`timescale 1ns/10ps
module ebms_ramp
  import ebms_pkg::*;
#(
  parameter int W = 16
)
(
  input  wire logic         sys_clk_i,
  input  wire logic         sys_rst_i,
  input  wire logic         load_i,
  input  wire logic [W-1:0] load_val_i,
  input  wire logic         step_i,
  input  wire logic [W-1:0] target_i,
  output logic      [W-1:0] value_o,
  output logic              done_o
);

  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
      value_o <= '0;
    else if (load_i)
      value_o <= load_val_i;
    else if (step_i && value_o < target_i)
      value_o <= ((target_i - value_o) < W'(EBMS_RAMP_STEP)) ? target_i : value_o + W'(EBMS_RAMP_STEP);
    else if (step_i && value_o > target_i)
      value_o <= target_i;
  end

  assign done_o = (value_o == target_i);

endmodule

// *** ebms_top.sv ***
// backup mode supervisor with AXI4-Lite register access
`timescale 1ns/10ps
module ebms_top
  import ebms_pkg::*;
#(
  parameter int CYCLE_CLKS = EBMS_CYCLE_CLKS
)
(
  input  wire logic        sys_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output ebms_act_t        actions_o,
  output logic [2:0]       backup_state_o,
  output logic [15:0]      gov_target_o,
  output logic [15:0]      torque_limit_o
);

  logic [31:0] ctrl;
  logic [31:0] cal;
  logic [31:0] speed;
  logic [31:0] idle;
  logic [31:0] press;
  logic [31:0] sensv;
  logic [1:0]  fault_sticky;
  logic        can_fault_log;
  logic [7:0]  aw_addr;
  logic [7:0]  ar_addr;
  logic        aw_held;
  logic        w_held;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        wr_fire;
  logic        wr_hit;

  // AXI write: address and data latched independently, response after both
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      else if (wr_fire)
        aw_held <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      else if (wr_fire)
        w_held <= 1'b0;
    end
  end

  always_comb
  begin
    case (aw_addr)
      EBMS_OFS_CTRL, EBMS_OFS_CAL, EBMS_OFS_SPEED, EBMS_OFS_IDLE,
      EBMS_OFS_PRESS, EBMS_OFS_SENSV, EBMS_OFS_FAULT: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= EBMS_RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? EBMS_RESP_OKAY : EBMS_RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  function automatic logic [31:0] ebms_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        r[i*8 +: 8] = new_v[i*8 +: 8];
    return r;
  endfunction

  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      ctrl  <= 32'h0000_0000;
      cal   <= EBMS_CAL_RESET;
      speed <= 32'h0000_0000;
      idle  <= EBMS_IDLE_RESET;
      press <= 32'h0000_0000;
      sensv <= 32'h0000_0000;
    end
    else if (wr_fire)
    begin
      case (aw_addr)
        EBMS_OFS_CTRL:  ctrl  <= ebms_merge(ctrl, w_data, w_strb);
        EBMS_OFS_CAL:   cal   <= ebms_merge(cal, w_data, w_strb);
        EBMS_OFS_SPEED: speed <= ebms_merge(speed, w_data, w_strb);
        EBMS_OFS_IDLE:  idle  <= ebms_merge(idle, w_data, w_strb);
        EBMS_OFS_PRESS: press <= ebms_merge(press, w_data, w_strb);
        EBMS_OFS_SENSV: sensv <= ebms_merge(sensv, w_data, w_strb);
        default: ;
      endcase
    end
  end

  // control cycle enable
  logic [$clog2(CYCLE_CLKS)-1:0] cyc_cnt;
  logic                          tick;
  assign tick = (cyc_cnt == '0);
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i || tick)
      cyc_cnt <= ($clog2(CYCLE_CLKS))'(CYCLE_CLKS - 1);
    else
      cyc_cnt <= cyc_cnt - 1'b1;
  end

  // decoded inputs
  logic        can_fault;
  logic [1:0]  mode_sel;
  logic [15:0] backup_nom;
  logic [15:0] act_speed;
  logic [15:0] lim_speed;
  logic [15:0] idle_speed;
  logic        ign_on;
  logic        ign_q;
  logic        mode_ever_valid;
  logic        was_mode2;
  ebms_state_t state;
  ebms_state_t next_state;

  assign ign_on     = ctrl[EBMS_B_IGN_ON];
  assign act_speed  = speed[15:0];
  assign lim_speed  = speed[31:16];
  assign idle_speed = idle[15:0];
  assign can_fault  = (ctrl[EBMS_B_NO_COMM] || ctrl[EBMS_B_BAD_TELEG] || ctrl[EBMS_B_CAN_DEFECT])
                      && ctrl[EBMS_B_FAULT_ACT];

  // idle[16]=automatic gearbox, idle[17]=bus application; bus subtracts offset held in idle[31:24]
  assign backup_nom = (idle[16] ? cal[31:16] : cal[15:0])
                      - (idle[17] ? {8'h00, idle[31:24]} : 16'h0000);

  always_comb
  begin
    if (ctrl[EBMS_B_BUF_FAIL] || !mode_ever_valid || was_mode2)
      mode_sel = 2'd0;
    else
      case (ctrl[EBMS_B_MODE_LO +: 2])
        2'b00:   mode_sel = 2'd1;
        2'b01:   mode_sel = 2'd2;
        default: mode_sel = 2'd0;
      endcase
  end

  // mode validity must be seen since ignition-on; mode 2 restart memory survives ignition-off
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      ign_q           <= 1'b0;
      mode_ever_valid <= 1'b0;
      was_mode2       <= 1'b0;
      can_fault_log   <= 1'b0;
    end
    else
    begin
      ign_q <= ign_on;
      if (ign_on && !ign_q)
        mode_ever_valid <= 1'b0;
      else if (ctrl[EBMS_B_MODE_VALID] && !ctrl[EBMS_B_NO_COMM] && !ctrl[EBMS_B_BAD_TELEG])
        mode_ever_valid <= 1'b1;
      if (!can_fault)
        was_mode2 <= 1'b0;
      else if (ign_q && !ign_on && state == EBMS_ST_CAN2)
        was_mode2 <= 1'b1;
      if (ctrl[EBMS_B_BUF_FAIL])
        can_fault_log <= 1'b1;
    end
  end

  // state machine, advanced once per control cycle
  logic        mp2_latched;
  logic        recov_done;

  always_comb
  begin
    next_state = state;
    case (state)
      EBMS_ST_NORMAL, EBMS_ST_CRANK, EBMS_ST_CAM, EBMS_ST_RECOV:
      begin
        if (mp2_latched)
          next_state = EBMS_ST_MP2;
        else if (can_fault || ctrl[EBMS_B_BUF_FAIL])
          next_state = (mode_sel == 2'd1) ? EBMS_ST_CAN1 :
                       (mode_sel == 2'd2) ? EBMS_ST_CAN2 : EBMS_ST_CAN0;
        else if (!ctrl[EBMS_B_CRANK_OK])
          next_state = EBMS_ST_CAM;
        else if (!ctrl[EBMS_B_CAM_OK])
          next_state = EBMS_ST_CRANK;
        else if (state == EBMS_ST_RECOV && !recov_done)
          next_state = EBMS_ST_RECOV;
        else
          next_state = EBMS_ST_NORMAL;
      end
      EBMS_ST_CAN0, EBMS_ST_CAN1, EBMS_ST_CAN2:
      begin
        if (mp2_latched)
          next_state = EBMS_ST_MP2;
        else if (!can_fault && !ctrl[EBMS_B_BUF_FAIL])
          next_state = EBMS_ST_RECOV;
        else
          next_state = (mode_sel == 2'd1) ? EBMS_ST_CAN1 :
                       (mode_sel == 2'd2) ? EBMS_ST_CAN2 : EBMS_ST_CAN0;
      end
      EBMS_ST_MP2:
        next_state = EBMS_ST_MP2;
      default:
        next_state = EBMS_ST_NORMAL;
    endcase
  end

  // a failed main processor is only left by power-off, i.e. reset
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
      mp2_latched <= 1'b0;
    else if (ctrl[EBMS_B_MAIN_FAIL])
      mp2_latched <= 1'b1;
  end

  logic        start_sync_miss;
  logic        entering_can;
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      state           <= EBMS_ST_NORMAL;
      start_sync_miss <= 1'b0;
    end
    else if (tick)
    begin
      state <= next_state;
      if (next_state == EBMS_ST_CRANK && state != EBMS_ST_CRANK)
        start_sync_miss <= !ctrl[EBMS_B_SYNCED];
    end
  end

  assign entering_can = tick && (next_state == EBMS_ST_CAN0)
                        && (state != EBMS_ST_CAN0);

  // a running entry holds its start value; only a standing or restarting engine climbs
  logic        ramp_arm;
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
      ramp_arm <= 1'b0;
    else if (ctrl[EBMS_B_STARTER_LO] && !ctrl[EBMS_B_RUNNING])
      ramp_arm <= 1'b1;
    else if (entering_can)
      ramp_arm <= !ctrl[EBMS_B_RUNNING];
  end

  // governor target ramp: mode 0 from standstill or restart
  logic [15:0] ramp_val;
  logic        ramp_done;
  logic [15:0] ramp_init;
  assign ramp_init = ctrl[EBMS_B_RUNNING] && act_speed < backup_nom ? act_speed :
                     ctrl[EBMS_B_RUNNING] ? backup_nom : act_speed;

  ebms_ramp #(.W(16)) u_gov_ramp
  (
    .sys_clk_i  (sys_clk_i),
    .sys_rst_i  (sys_rst_i),
    .load_i     (entering_can || (ctrl[EBMS_B_STARTER_LO] && !ctrl[EBMS_B_RUNNING])),
    .load_val_i (ramp_init),
    .step_i     (tick && state == EBMS_ST_CAN0 && ramp_arm),
    .target_i   (backup_nom),
    .value_o    (ramp_val),
    .done_o     ()
  );

  // pedal authority ramp after leaving CAN backup
  logic [15:0] torque_backup;
  logic [15:0] pedal_val;
  assign torque_backup = (state == EBMS_ST_CAN0 && ctrl[EBMS_B_RUNNING]) ?
                         press[31:16] : EBMS_BOOST_CONST;

  ebms_ramp #(.W(16)) u_pedal_ramp
  (
    .sys_clk_i  (sys_clk_i),
    .sys_rst_i  (sys_rst_i),
    .load_i     (state != EBMS_ST_RECOV),
    .load_val_i (torque_backup),
    .step_i     (tick && state == EBMS_ST_RECOV),
    .target_i   (16'hFFFF),
    .value_o    (pedal_val),
    .done_o     (recov_done)
  );

  logic [15:0] raw_target;
  logic [15:0] next_gov;
  always_comb
  begin
    case (state)
      EBMS_ST_CAN0: raw_target = ramp_val;
      EBMS_ST_CAN1: raw_target = idle_speed;
      EBMS_ST_MP2:  raw_target = (idle[15:0] < EBMS_MP2_MIN) ? EBMS_MP2_MIN :
                                 (idle[15:0] > EBMS_MP2_MAX) ? EBMS_MP2_MAX : idle[15:0];
      default:      raw_target = act_speed;
    endcase
    if ((state == EBMS_ST_CAN0 || state == EBMS_ST_CAN1) && raw_target < idle_speed)
      next_gov = idle_speed;
    else if ((state == EBMS_ST_CAN0 || state == EBMS_ST_CAN1) && raw_target > lim_speed)
      next_gov = lim_speed;
    else
      next_gov = raw_target;
  end

  // ambient pressure substitute: press[15:0] boost, press[31:16] vehicle speed torque limit
  logic [15:0] amb_val;
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
      amb_val <= EBMS_AMB_CONST;
    else if (tick && ctrl[EBMS_B_AMB_FAULT])
    begin
      if (ctrl[EBMS_B_BOOST_BAD])
        amb_val <= EBMS_AMB_CONST;
      else if (!ctrl[EBMS_B_ABOVE_THR])
        amb_val <= press[15:0];
    end
  end

  // sensor plausibility, sticky until written
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
      fault_sticky <= 2'b00;
    else
    begin
      fault_sticky <= (wr_fire && aw_addr == EBMS_OFS_FAULT) ? (fault_sticky & ~w_data[1:0]) : fault_sticky;
      if (sensv[15:0] < EBMS_SENS_MIN)
        fault_sticky[0] <= 1'b1;
      if (sensv[15:0] > EBMS_SENS_MAX)
        fault_sticky[1] <= 1'b1;
    end
  end

  // outputs registered on the control cycle
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      actions_o      <= '0;
      backup_state_o <= EBMS_ST_NORMAL;
      gov_target_o   <= 16'h0000;
      torque_limit_o <= 16'hFFFF;
    end
    else if (tick)
    begin
      backup_state_o <= state;
      gov_target_o   <= next_gov;
      torque_limit_o <= (state == EBMS_ST_RECOV) ? pedal_val :
                        (state == EBMS_ST_CAN0 || state == EBMS_ST_CAN1) ? torque_backup :
                        (state == EBMS_ST_CRANK || state == EBMS_ST_CAM) ? EBMS_BOOST_CONST : 16'hFFFF;
      actions_o.double_inject  <= (state == EBMS_ST_CRANK) && start_sync_miss;
      actions_o.engine_protect <= (state == EBMS_ST_CRANK) || (state == EBMS_ST_CAM);
      actions_o.cam_timing     <= !ctrl[EBMS_B_CRANK_OK] || (state == EBMS_ST_CAM);
      actions_o.inject_lock    <= (state == EBMS_ST_CAN2);
      actions_o.starter_lock   <= (state == EBMS_ST_CAN2);
      actions_o.boost_ctrl_off <= ctrl[EBMS_B_BOOST_BAD] || ctrl[EBMS_B_BOOSTPATH] || ctrl[EBMS_B_BOOST_DEV];
      actions_o.brake_unavail  <= ctrl[EBMS_B_BOOST_BAD] || ctrl[EBMS_B_BOOSTPATH] || ctrl[EBMS_B_BOOST_DEV];
      actions_o.amb_unavail    <= ctrl[EBMS_B_AMB_FAULT] && ctrl[EBMS_B_BOOST_BAD];
      actions_o.can_silent     <= ctrl[EBMS_B_BUF_FAIL];
    end
  end

  // AXI read
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= EBMS_RESP_OKAY;
      ar_addr      <= 8'h00;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      ar_addr      <= s_axi_araddr;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= EBMS_RESP_OKAY;
      case (s_axi_araddr)
        EBMS_OFS_CTRL:   s_axi_rdata <= ctrl;
        EBMS_OFS_CAL:    s_axi_rdata <= cal;
        EBMS_OFS_SPEED:  s_axi_rdata <= speed;
        EBMS_OFS_IDLE:   s_axi_rdata <= idle;
        EBMS_OFS_PRESS:  s_axi_rdata <= press;
        EBMS_OFS_SENSV:  s_axi_rdata <= sensv;
        EBMS_OFS_STATUS: s_axi_rdata <= {15'h0000, actions_o, 5'h00, backup_state_o};
        EBMS_OFS_GOV:    s_axi_rdata <= {torque_limit_o, gov_target_o};
        EBMS_OFS_FAULT:  s_axi_rdata <= {29'h0, can_fault_log, fault_sticky};
        EBMS_OFS_AMB:    s_axi_rdata <= {16'h0000, amb_val};
        default:
        begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= EBMS_RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

endmodule

// *** ebms_veu_model.sv ***
// vehicle electronics unit model: turns link state and mode setting into CAN status bits
`timescale 1ns/10ps
module ebms_veu_model
  import ebms_pkg::*;
(
  input  wire logic        fault_i,
  input  wire logic        link_ok_i,
  input  wire logic [1:0]  mode_i,
  output logic      [31:0] can_bits_o
);
  // a broken link delivers no mode word, so the field reads as zero
  always_comb
  begin
    can_bits_o = 32'h0000_0000;
    can_bits_o[EBMS_B_NO_COMM] = fault_i && !link_ok_i;
    can_bits_o[EBMS_B_CAN_DEFECT] = fault_i && link_ok_i;
    can_bits_o[EBMS_B_FAULT_ACT] = fault_i;
    can_bits_o[EBMS_B_MODE_VALID] = link_ok_i;
    can_bits_o[EBMS_B_MODE_LO+:2] = link_ok_i ? mode_i : 2'h0;
  end
endmodule

// *** ebms_monitor.sv ***
// concurrent checks on the supervisor bus and control outputs
`timescale 1ns/10ps
module ebms_monitor
  import ebms_pkg::*;
#(
  parameter int CYCLE_CLKS = 8
)
(
  input wire logic        sys_clk_i,
  input wire logic        sys_rst_i,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire ebms_act_t   actions_o,
  input wire logic [2:0]  backup_state_o,
  input wire logic [15:0] gov_target_o,
  input wire logic [15:0] torque_limit_o
);
  default clocking mc @(posedge sys_clk_i);
  endclocking
  default disable iff (sys_rst_i);
  // repetition counts assume CYCLE_CLKS of 8
  sequence s_mp2_held;
    (backup_state_o == EBMS_ST_MP2) [*8];
  endsequence
  sequence s_locked;
    actions_o.inject_lock && actions_o.starter_lock;
  endsequence
  a_reset_torque: assert property ($fell(sys_rst_i) |-> torque_limit_o == 16'hFFFF)
    else $error("torque limit not free after reset");
  a_state_hold: assert property ($changed(backup_state_o) |=> $stable(backup_state_o) [*7])
    else $error("state changed between ticks");
  a_mode2_lock: assert property ($rose(backup_state_o == EBMS_ST_CAN2) |-> ##[0:9] s_locked)
    else $error("mode 2 without lockout");
  a_mp2_range: assert property (s_mp2_held |=> gov_target_o >= EBMS_MP2_MIN && gov_target_o <= EBMS_MP2_MAX)
    else $error("backup processor speed out of range");
  a_cam_timing: assert property ((backup_state_o == EBMS_ST_CAM) |-> actions_o.cam_timing)
    else $error("cam timing missing");
  a_crank_protect: assert property ((backup_state_o == EBMS_ST_CRANK) |-> actions_o.engine_protect)
    else $error("engine protection missing");
  a_double_protect: assert property (actions_o.double_inject |-> actions_o.engine_protect)
    else $error("double injection without protection");
  a_normal_free: assert property ((backup_state_o == EBMS_ST_NORMAL) |-> torque_limit_o == 16'hFFFF)
    else $error("torque limited in normal state");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
endmodule

// *** ebms_top_bench.sv ***
// self-checking bench for the backup mode supervisor
`timescale 1ns/10ps
module ebms_top_bench
  import ebms_pkg::*;
();
  localparam int CYC = 8;
  localparam int LIMIT = 20000;
  localparam logic [31:0] BASE = 32'h0004_000F;
  localparam ebms_state_t MODE_EXP [4] = '{EBMS_ST_CAN1, EBMS_ST_CAN2, EBMS_ST_CAN0, EBMS_ST_CAN0};
  logic        sys_clk_i, sys_rst_i, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, veu_fault, veu_link;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, can_bits;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, veu_mode;
  logic [15:0] gov, torque;
  logic [2:0]  state;
  ebms_act_t   act;
  int          bad_count, checks, cyc;

  ebms_top #(.CYCLE_CLKS(CYC)) u_dut
  (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .actions_o(act),
    .backup_state_o(state), .gov_target_o(gov), .torque_limit_o(torque)
  );
  ebms_veu_model u_veu
  (
    .fault_i(veu_fault), .link_ok_i(veu_link), .mode_i(veu_mode), .can_bits_o(can_bits)
  );

  initial
  begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end

  task automatic final_report();
    begin
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask

  always @(posedge sys_clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == LIMIT)
    begin
      bad_count++;
      final_report();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      checks++;
      if (got !== exp)
      begin
        bad_count++;
        $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask

  task automatic rst();
    begin
      @(posedge sys_clk_i);
      sys_rst_i <= 1'b1;
      repeat (20) @(posedge sys_clk_i);
      sys_rst_i <= 1'b0;
    end
  endtask

  // write and wait out the control ticks so outputs reflect it
  task automatic set(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    begin
      @(posedge sys_clk_i);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
        @(posedge sys_clk_i);
        if (awvalid && awready)
          awvalid <= 1'b0;
        if (wvalid && wready)
          wvalid <= 1'b0;
      end while (!bvalid);
      chk(32'(bresp), 32'(er));
      bready <= 1'b0;
      repeat (4 * CYC) @(posedge sys_clk_i);
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp, input logic [1:0] er);
    begin
      @(posedge sys_clk_i);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
        @(posedge sys_clk_i);
        if (arvalid && arready)
          arvalid <= 1'b0;
      end while (!rvalid);
      chk(rdata & m, exp);
      chk(32'(rresp), 32'(er));
      rready <= 1'b0;
    end
  endtask

  initial
  begin
    sys_rst_i = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready, checks, bad_count} = '0;
    {awaddr, araddr, wdata, veu_fault, veu_mode} = '0;
    wstrb = 4'hF;
    veu_link = 1'b1;
    rst();
    chk(32'(torque), 32'h0000_FFFF);
    rchk(EBMS_OFS_CAL, '1, EBMS_CAL_RESET, EBMS_RESP_OKAY);
    rchk(8'h3C, '1, 32'h0, EBMS_RESP_SLVERR);
    set(8'h3C, 32'h1, EBMS_RESP_SLVERR);
    $display("test registers done");
    rst();
    set(EBMS_OFS_CTRL, BASE & ~32'h1, EBMS_RESP_OKAY);
    chk(32'(state), 32'(EBMS_ST_CRANK));
    chk(32'(act.double_inject), 32'h0);
    chk(32'(act.engine_protect), 32'h1);
    rst();
    set(EBMS_OFS_CTRL, BASE & ~32'h5, EBMS_RESP_OKAY);
    chk(32'(act.double_inject), 32'h1);
    rst();
    set(EBMS_OFS_CTRL, BASE & ~32'h2, EBMS_RESP_OKAY);
    chk(32'(state), 32'(EBMS_ST_CAM));
    chk(32'(act.cam_timing), 32'h1);
    chk(32'(act.engine_protect), 32'h1);
    $display("test sensor backup done");
    for (int m = 0; m < 4; m++)
    begin
      rst();
      veu_fault = 1'b1;
      veu_mode = 2'(m);
      @(posedge sys_clk_i);
      set(EBMS_OFS_SPEED, (m == 3) ? 32'h0800_0700 : 32'h0800_0400, EBMS_RESP_OKAY);
      set(EBMS_OFS_CTRL, BASE | can_bits, EBMS_RESP_OKAY);
      chk(32'(state), 32'(MODE_EXP[m]));
      if (m == 0)
      begin
        chk(32'(gov), 32'(EBMS_IDLE_RESET[15:0]));
        chk(32'(torque), 32'(EBMS_BOOST_CONST));
      end
      if (m >= 2)
        chk(32'(gov), (m == 3) ? 32'h05DC : 32'h0400);
      if (m == 1)
      begin
        chk(32'({act.inject_lock, act.starter_lock}), 32'h3);
        veu_fault = 1'b0;
        @(posedge sys_clk_i);
        set(EBMS_OFS_CTRL, BASE | can_bits, EBMS_RESP_OKAY);
        chk(32'(act.starter_lock), 32'h0);
      end
    end
    rst();
    veu_fault = 1'b1;
    veu_link = 1'b0;
    @(posedge sys_clk_i);
    set(EBMS_OFS_CTRL, BASE | can_bits, EBMS_RESP_OKAY);
    chk(32'(state), 32'(EBMS_ST_CAN0));
    $display("test can backup done");
    rst();
    set(EBMS_OFS_CTRL, BASE | 32'h0001_0000, EBMS_RESP_OKAY);
    chk(32'(state), 32'(EBMS_ST_CAN0));
    chk(32'(act.can_silent), 32'h1);
    set(EBMS_OFS_SENSV, 32'h0000_0100, EBMS_RESP_OKAY);
    set(EBMS_OFS_FAULT, 32'h0000_0003, EBMS_RESP_OKAY);
    rchk(EBMS_OFS_FAULT, 32'h3, 32'h0, EBMS_RESP_OKAY);
    set(EBMS_OFS_SENSV, 32'h0000_0010, EBMS_RESP_OKAY);
    set(EBMS_OFS_SENSV, 32'h0000_0FFF, EBMS_RESP_OKAY);
    rchk(EBMS_OFS_FAULT, 32'h7, 32'h7, EBMS_RESP_OKAY);
    rst();
    set(EBMS_OFS_PRESS, 32'h0000_0123, EBMS_RESP_OKAY);
    set(EBMS_OFS_CTRL, BASE | 32'h0000_0800, EBMS_RESP_OKAY);
    rchk(EBMS_OFS_AMB, 32'hFFFF, 32'h0000_0123, EBMS_RESP_OKAY);
    set(EBMS_OFS_CTRL, BASE | 32'h0000_1800, EBMS_RESP_OKAY);
    chk(32'({act.boost_ctrl_off, act.brake_unavail}), 32'h3);
    chk(32'(act.amb_unavail), 32'h1);
    rchk(EBMS_OFS_AMB, 32'hFFFF, 32'(EBMS_AMB_CONST), EBMS_RESP_OKAY);
    rst();
    set(EBMS_OFS_CTRL, BASE | 32'h0002_0000, EBMS_RESP_OKAY);
    chk(32'(state), 32'(EBMS_ST_MP2));
    $display("test faults done");
    final_report();
  end
endmodule

bind ebms_top ebms_monitor #(.CYCLE_CLKS(CYCLE_CLKS)) u_mon
(
  .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .actions_o(actions_o),
  .backup_state_o(backup_state_o), .gov_target_o(gov_target_o), .torque_limit_o(torque_limit_o)
);
